// ==== inc/dsg_regs_defs.vh ====
// Constants for the deserializer status, pin and error-counter register bank.
`ifndef DSG_REGS_DEFS_VH
`define DSG_REGS_DEFS_VH

`define DSG_ADDR_TIMEOUT 8'h0D
`define DSG_ADDR_PINS 8'h0E
`define DSG_ADDR_DET_THR 8'h0F
`define DSG_ADDR_DET_CNT 8'h10
`define DSG_ADDR_CORR_THR 8'h11
`define DSG_ADDR_CORR_CNT 8'h12
`define DSG_ADDR_PAT_CNT 8'h13
`define DSG_ADDR_PAT_RES 8'h14
`define DSG_ADDR_RSVD_A 8'h15
`define DSG_ADDR_RSVD_B 8'h16
`define DSG_ADDR_RSVD_C 8'h17
`define DSG_ADDR_RSVD_D 8'h18
`define DSG_ADDR_RSVD_E 8'h19
`define DSG_ADDR_RSVD_F 8'h1A
`define DSG_ADDR_RSVD_G 8'h1B
`define DSG_ADDR_RSVD_H 8'h1C
`define DSG_ADDR_STRAPS 8'h1D
`define DSG_ADDR_IDENT 8'h1E
`define DSG_ADDR_CAPREV 8'h1F

`define DSG_RST_RSVD_A 8'h20
`define DSG_RST_RSVD_B 8'h30
`define DSG_RST_RSVD_C 8'h54
`define DSG_RST_RSVD_D 8'h30
`define DSG_RST_RSVD_E 8'hC8
`define DSG_RST_ZERO8 8'h00
`define DSG_RST_TIMEOUT 2'h2
`define DSG_PINS_TOP 2'h1

`define DSG_PIN_FWD_BIT 5
`define DSG_PIN_GPI_BIT 4
`define DSG_PIN_P1OUT_BIT 3
`define DSG_PIN_P1IN_BIT 2
`define DSG_PIN_P0OUT_BIT 1
`define DSG_PIN_P0IN_BIT 0

`define DSG_ERROR_OUTPUT_SELECT_DET 2'h0
`define DSG_ERROR_OUTPUT_SELECT_CORR 2'h1

`define DSG_CNT_MAX 8'hFF
`define DSG_CNT_ONE 8'h01

`define DSG_CLK_PERIOD_NS 50
`define DSG_AUTOCLR_DELAY_NS 1000
// Autoclear delay in clock cycles, 1000 ns at a 50 ns period, sized to the timer width.
`define DSG_AUTOCLR_CYCLES 5'h14
`define DSG_TMR_W 5

`define DSG_DEF_IDENT 8'h5C
`define DSG_DEF_REVISION 4'h1
`define DSG_DEF_CAPABLE 1'b0

`endif

// ==== rtl/dsg_status_gpio_regs.v ====
// Upper control register bank: slave timeout, pins, error thresholds and counters, identity.
`timescale 1ns/1ps
`default_nettype none
`include "dsg_regs_defs.vh"

module dsg_status_gpio_regs #(
  parameter [7:0] DEVICE_IDENT = `DSG_DEF_IDENT,
  parameter [3:0] DEVICE_REVISION = `DSG_DEF_REVISION,
  parameter [0:0] PROTECTION_CAPABLE = `DSG_DEF_CAPABLE
) (
  input wire clock,
  input wire reset_n,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  output reg regRdValid,
  input wire [1:0] errorOutputSelect,
  input wire errorCountAutoclear,
  input wire detectedErrorEvent,
  input wire correctedErrorEvent,
  input wire patternErrorEvent,
  input wire patternTestPassed,
  input wire inputPinLevel,
  input wire pin0SensedLevel,
  input wire pin1SensedLevel,
  input wire cableTypeStrap,
  input wire coaxInputSelect,
  input wire hostLinkSelect,
  input wire localChannelEnable,
  output reg [1:0] bridgeSlaveTimeoutSel,
  output reg pin0DriveLevel,
  output reg pin1DriveLevel,
  output reg inputForwardLevel,
  output reg errorOut
);

  // Seven asynchronous pin levels share one two-stage synchroniser.
  localparam SYNC_W = 7;
  localparam [`DSG_TMR_W-1:0] AUTOCLR_CYCLES = `DSG_AUTOCLR_CYCLES;
  localparam [`DSG_TMR_W-1:0] TMR_ONE = 5'h01;
  localparam [`DSG_TMR_W-1:0] TMR_ZERO = 5'h00;

  wire [SYNC_W-1:0] pinRaw;
  reg [SYNC_W-1:0] pinMeta_q;
  reg [SYNC_W-1:0] pinSync_q;

  reg [1:0] timeoutSel_q;
  reg forwardEnable_q;
  reg pin0Out_q;
  reg pin1Out_q;
  reg [7:0] detected_error_threshold_q;
  reg [7:0] corrected_error_threshold_q;
  reg [7:0] detCnt_q;
  reg [7:0] detCnt_d;
  reg [7:0] corrCnt_q;
  reg [7:0] corrCnt_d;
  reg [7:0] patCnt_q;
  reg patPassed_q;
  reg errOut_d;
  reg [`DSG_TMR_W-1:0] clrTimer_q;
  reg [`DSG_TMR_W-1:0] clrTimer_d;
  reg autoClear;
  reg [7:0] rdMux;

  wire wrTimeout;
  wire wrPins;
  wire wrDetThr;
  wire wrCorrThr;
  wire syncGpi;
  wire syncPin0;
  wire syncPin1;
  wire [3:0] syncStraps;

  assign pinRaw = {cableTypeStrap, coaxInputSelect, hostLinkSelect, localChannelEnable,
                   pin1SensedLevel, pin0SensedLevel, inputPinLevel};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : gSync
      always @(posedge clock) begin
        if (!reset_n) begin
          pinMeta_q[gi] <= 1'b0;
          pinSync_q[gi] <= 1'b0;
        end else begin
          pinMeta_q[gi] <= pinRaw[gi];
          pinSync_q[gi] <= pinMeta_q[gi];
        end
      end
    end
  endgenerate

  assign syncGpi = pinSync_q[0];
  assign syncPin0 = pinSync_q[1];
  assign syncPin1 = pinSync_q[2];
  assign syncStraps = pinSync_q[6:3];

  // Only the writable registers decode a write; every other address ignores it.
  assign wrTimeout = regWrite && (regAddr == `DSG_ADDR_TIMEOUT);
  assign wrPins = regWrite && (regAddr == `DSG_ADDR_PINS);
  assign wrDetThr = regWrite && (regAddr == `DSG_ADDR_DET_THR);
  assign wrCorrThr = regWrite && (regAddr == `DSG_ADDR_CORR_THR);

  always @(posedge clock) begin
    if (!reset_n) begin
      timeoutSel_q <= `DSG_RST_TIMEOUT;
      forwardEnable_q <= 1'b1;
      pin0Out_q <= 1'b1;
      pin1Out_q <= 1'b1;
      detected_error_threshold_q <= `DSG_RST_ZERO8;
      corrected_error_threshold_q <= `DSG_RST_ZERO8;
    end else begin
      if (wrTimeout) begin
        timeoutSel_q <= regWrData[1:0];
      end
      if (wrPins) begin
        forwardEnable_q <= regWrData[`DSG_PIN_FWD_BIT];
        pin1Out_q <= regWrData[`DSG_PIN_P1OUT_BIT];
        pin0Out_q <= regWrData[`DSG_PIN_P0OUT_BIT];
      end
      if (wrDetThr) begin
        detected_error_threshold_q <= regWrData;
      end
      if (wrCorrThr) begin
        corrected_error_threshold_q <= regWrData;
      end
    end
  end

  // The error output compares the live counters and is registered, so it drops one cycle after an autoclear zeroes them.
  always @* begin
    case (errorOutputSelect)
      `DSG_ERROR_OUTPUT_SELECT_DET: errOut_d = (detCnt_q > detected_error_threshold_q);
      `DSG_ERROR_OUTPUT_SELECT_CORR: errOut_d = (corrCnt_q > corrected_error_threshold_q);
      default: errOut_d = (detCnt_q > detected_error_threshold_q) || (corrCnt_q > corrected_error_threshold_q);
    endcase
  end

  // The timer starts on the rising edge of the error output and clears the counters when it
  // reaches the delay; turning autoclear off mid-wait abandons the pending clear.
  always @* begin
    clrTimer_d = TMR_ZERO;
    autoClear = 1'b0;
    if (errorCountAutoclear) begin
      if (clrTimer_q != TMR_ZERO) begin
        if (clrTimer_q == AUTOCLR_CYCLES) begin
          autoClear = 1'b1;
        end else begin
          clrTimer_d = clrTimer_q + TMR_ONE;
        end
      end else if (errOut_d && !errorOut) begin
        clrTimer_d = TMR_ONE;
      end
    end
  end

  // Counters saturate rather than wrap, so a large count never reads as a small one.
  // An error arriving in the clear cycle is kept as a count of one.
  always @* begin
    if (autoClear) begin
      detCnt_d = detectedErrorEvent ? `DSG_CNT_ONE : `DSG_RST_ZERO8;
      corrCnt_d = correctedErrorEvent ? `DSG_CNT_ONE : `DSG_RST_ZERO8;
    end else begin
      detCnt_d = detCnt_q;
      corrCnt_d = corrCnt_q;
      if (detectedErrorEvent && (detCnt_q != `DSG_CNT_MAX)) begin
        detCnt_d = detCnt_q + `DSG_CNT_ONE;
      end
      if (correctedErrorEvent && (corrCnt_q != `DSG_CNT_MAX)) begin
        corrCnt_d = corrCnt_q + `DSG_CNT_ONE;
      end
    end
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      detCnt_q <= `DSG_RST_ZERO8;
      corrCnt_q <= `DSG_RST_ZERO8;
      patCnt_q <= `DSG_RST_ZERO8;
      patPassed_q <= 1'b0;
      clrTimer_q <= TMR_ZERO;
    end else begin
      detCnt_q <= detCnt_d;
      corrCnt_q <= corrCnt_d;
      clrTimer_q <= clrTimer_d;
      if (patternErrorEvent && (patCnt_q != `DSG_CNT_MAX)) begin
        patCnt_q <= patCnt_q + `DSG_CNT_ONE;
      end
      patPassed_q <= patternTestPassed;
    end
  end

  always @* begin
    case (regAddr)
      `DSG_ADDR_TIMEOUT: rdMux = {6'h00, timeoutSel_q};
      `DSG_ADDR_PINS: rdMux = {`DSG_PINS_TOP, forwardEnable_q, syncGpi,
                               pin1Out_q, syncPin1, pin0Out_q, syncPin0};
      `DSG_ADDR_DET_THR: rdMux = detected_error_threshold_q;
      `DSG_ADDR_DET_CNT: rdMux = detCnt_q;
      `DSG_ADDR_CORR_THR: rdMux = corrected_error_threshold_q;
      `DSG_ADDR_CORR_CNT: rdMux = corrCnt_q;
      `DSG_ADDR_PAT_CNT: rdMux = patCnt_q;
      `DSG_ADDR_PAT_RES: rdMux = {patPassed_q, 7'h00};
      `DSG_ADDR_RSVD_A: rdMux = `DSG_RST_RSVD_A;
      `DSG_ADDR_RSVD_B: rdMux = `DSG_RST_RSVD_B;
      `DSG_ADDR_RSVD_C: rdMux = `DSG_RST_RSVD_C;
      `DSG_ADDR_RSVD_D: rdMux = `DSG_RST_RSVD_D;
      `DSG_ADDR_RSVD_E: rdMux = `DSG_RST_RSVD_E;
      `DSG_ADDR_STRAPS: rdMux = {syncStraps, 4'h0};
      `DSG_ADDR_IDENT: rdMux = DEVICE_IDENT;
      `DSG_ADDR_CAPREV: rdMux = {3'h0, PROTECTION_CAPABLE, DEVICE_REVISION};
      default: rdMux = `DSG_RST_ZERO8;
    endcase
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      regRdData <= `DSG_RST_ZERO8;
      regRdValid <= 1'b0;
      bridgeSlaveTimeoutSel <= `DSG_RST_TIMEOUT;
      pin0DriveLevel <= 1'b1;
      pin1DriveLevel <= 1'b1;
      inputForwardLevel <= 1'b0;
      errorOut <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdData <= rdMux;
      end
      bridgeSlaveTimeoutSel <= timeoutSel_q;
      pin0DriveLevel <= pin0Out_q;
      pin1DriveLevel <= pin1Out_q;
      inputForwardLevel <= forwardEnable_q & syncGpi;
      errorOut <= errOut_d;
    end
  end

endmodule // dsg_status_gpio_regs
`default_nettype wire

// ==== verification/dsg_regs_props.sv ====
// Checker for the status, pin and error-counter register bank.
`timescale 1ns/1ps
`default_nettype none
module dsg_regs_props (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic errorCountAutoclear,
  input wire logic pin0DriveLevel,
  input wire logic pin1DriveLevel,
  input wire logic errorOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_RD_ANSWER: assert property (regRead |=> regRdValid) else $error("read not answered");
  AST_RD_QUIET: assert property (!regRead |=> !regRdValid) else $error("spurious read valid");
  AST_PIN0_DRIVE: assert property (regWrite && regAddr == 8'h0E |-> ##2
    pin0DriveLevel == $past(regWrData[1], 2)) else $error("pin0 drive wrong");
  AST_PIN1_DRIVE: assert property (regWrite && regAddr == 8'h0E |-> ##2
    pin1DriveLevel == $past(regWrData[3], 2)) else $error("pin1 drive wrong");
  AST_PAT_LOW: assert property (regRead && regAddr == 8'h14 |=> regRdData[6:0] == 7'h00)
    else $error("pattern result low bits set");
  AST_STRAP_LOW: assert property (regRead && regAddr == 8'h1D |=> regRdData[3:0] == 4'h0)
    else $error("strap low bits set");
  AST_RSVD_FIXED: assert property (regRead && regAddr == 8'h19 |=> regRdData == 8'hC8)
    else $error("reserved value changed");
  // Autoclear waits about 20 cycles, so the output must not drop early.
  AST_CLEAR_HOLD: assert property ($rose(errorOut) && errorCountAutoclear |=> errorOut [*8])
    else $error("error output cleared early");
  AST_CLEAR_DONE: assert property ($rose(errorOut) && errorCountAutoclear |-> ##[1:24] !errorOut)
    else $error("autoclear did not happen");
  AST_NO_CLEAR: assert property ($rose(errorOut) && !errorCountAutoclear |=> errorOut [*8])
    else $error("error output cleared without autoclear");
  cover property (regWrite && regAddr == 8'h0E);
  cover property ($rose(errorOut));
  cover property ($fell(errorOut) && errorCountAutoclear);
endmodule // dsg_regs_props
bind dsg_status_gpio_regs dsg_regs_props u_props (.*);
`default_nettype wire

// ==== verification/dsg_host_model.sv ====
// Host model that reaches the registers over the control channel port.
`timescale 1ns/1ps
`default_nettype none
module dsg_host_model (
  input wire logic clock,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'h0;
    regRead = 1'h0;
  end
  // Idle address and data are inverted so a stale value never looks valid.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic v);
    @(posedge clock);
    #1 {regAddr, regWrData, regWrite, regRead} = {a, d, wr, !wr};
    @(posedge clock);
    #1 {regAddr, regWrData, regWrite, regRead} = {~a, ~d, 2'h0};
    v = regRdValid;
    q = regRdData;
  endtask
endmodule // dsg_host_model
`default_nettype wire

// ==== verification/test_deser_status_gpio_regs.sv ====
// Testbench for the status, pin and error-counter register bank.
`timescale 1ns/1ps
`default_nettype none
`include "dsg_regs_defs.vh"
module test_deser_status_gpio_regs;
  logic clock = 1'h0, reset_n = 1'h0, regWrite, regRead, regRdValid, v;
  logic [7:0] regAddr, regWrData, regRdData, q;
  logic [1:0] errorOutputSelect = 2'h0, bridgeSlaveTimeoutSel;
  logic errorCountAutoclear = 1'h0, patternTestPassed = 1'h0, inputPinLevel = 1'h1;
  logic detectedErrorEvent = 1'h0, correctedErrorEvent = 1'h0, patternErrorEvent = 1'h0;
  logic pin0SensedLevel = 1'h1, pin1SensedLevel = 1'h0, cableTypeStrap = 1'h1;
  logic coaxInputSelect = 1'h0, hostLinkSelect = 1'h1, localChannelEnable = 1'h0;
  logic pin0DriveLevel, pin1DriveLevel, inputForwardLevel, errorOut;
  int err_total = 0, num_checks = 0, cycles = 0;
  // Row: write flag, address, write data, expected read, expected forward level.
  logic [25:0] rows [23] = '{
    {1'h0, 8'h0D, 8'h00, 8'h02, 1'h1}, {1'h0, 8'h0E, 8'h00, 8'h7B, 1'h1},
    {1'h0, 8'h0F, 8'h00, 8'h00, 1'h1}, {1'h0, 8'h11, 8'h00, 8'h00, 1'h1},
    {1'h0, 8'h12, 8'h00, 8'h00, 1'h1}, {1'h1, 8'h0D, 8'h00, 8'h00, 1'h1},
    {1'h1, 8'h0D, 8'h01, 8'h01, 1'h1}, {1'h1, 8'h0D, 8'hFE, 8'h02, 1'h1},
    {1'h1, 8'h0D, 8'hFF, 8'h03, 1'h1}, {1'h1, 8'h0E, 8'h00, 8'h51, 1'h0},
    {1'h1, 8'h0E, 8'hFF, 8'h7B, 1'h1}, {1'h1, 8'h11, 8'h5A, 8'h5A, 1'h1},
    {1'h1, 8'h10, 8'hFF, 8'h00, 1'h1}, {1'h1, 8'h13, 8'hFF, 8'h00, 1'h1},
    {1'h1, 8'h14, 8'hFF, 8'h00, 1'h1}, {1'h1, 8'h16, 8'h00, 8'h30, 1'h1},
    {1'h1, 8'h19, 8'h00, 8'hC8, 1'h1}, {1'h1, 8'h1A, 8'hFF, 8'h00, 1'h1},
    {1'h1, 8'h1D, 8'h0F, 8'hA0, 1'h1}, {1'h1, 8'h1E, 8'hFF, `DSG_DEF_IDENT, 1'h1},
    {1'h1, 8'h1F, 8'hFF, {3'h0, `DSG_DEF_CAPABLE, `DSG_DEF_REVISION}, 1'h1},
    {1'h1, 8'h40, 8'hFF, 8'h00, 1'h1}, {1'h1, 8'h0F, 8'h02, 8'h02, 1'h1}};
  dsg_status_gpio_regs dut (.*);
  dsg_host_model host (.*);
  always #25 clock = ~clock;
  task report_and_stop;
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      report_and_stop;
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chkb(input logic b, input logic e);
    chk({7'h0, b}, {7'h0, e});
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'h0, a, 8'h00, q, v);
    chkb(v, 1'h1);
    chk(q, e);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task pulse(input logic [2:0] w, input int n);
    @(posedge clock);
    #1 {patternErrorEvent, correctedErrorEvent, detectedErrorEvent} = w;
    repeat (n) @(posedge clock);
    #1 {patternErrorEvent, correctedErrorEvent, detectedErrorEvent} = 3'h0;
  endtask
  initial begin
    tick(12);
    reset_n = 1'h1;
    chk({6'h0, pin1DriveLevel, pin0DriveLevel}, 8'h03);
    // The pin synchronisers restart from zero, so the registered forward level needs three edges to fill.
    tick(2);
    for (int i = 0; i < 23; i++) begin
      if (rows[i][25]) host.xfer(1'h1, rows[i][24:17], rows[i][16:9], q, v);
      rdc(rows[i][24:17], rows[i][8:1]);
      chkb(inputForwardLevel, rows[i][0]);
      if (rows[i][24:17] == 8'h0D) chk({6'h0, bridgeSlaveTimeoutSel}, rows[i][8:1]);
    end
    host.xfer(1'h1, 8'h11, 8'h00, q, v);
    pulse(3'h1, 2);
    tick(2);
    chkb(errorOut, 1'h0);
    pulse(3'h1, 1);
    tick(2);
    chkb(errorOut, 1'h1);
    rdc(8'h10, 8'h03);
    tick(9);
    errorOutputSelect = 2'h1;
    tick(3);
    chkb(errorOut, 1'h0);
    pulse(3'h2, 1);
    tick(2);
    chkb(errorOut, 1'h1);
    rdc(8'h12, 8'h01);
    for (int s = 2; s < 5; s++) begin
      errorOutputSelect = 2'(s);
      tick(3);
      chkb(errorOut, 1'h1);
    end
    host.xfer(1'h1, 8'h0F, 8'hFF, q, v);
    tick(3);
    chkb(errorOut, 1'h0);
    errorCountAutoclear = 1'h1;
    host.xfer(1'h1, 8'h0F, 8'h00, q, v);
    tick(30);
    chkb(errorOut, 1'h0);
    rdc(8'h10, 8'h00);
    rdc(8'h12, 8'h00);
    errorCountAutoclear = 1'h0;
    patternTestPassed = 1'h1;
    pulse(3'h4, 2);
    tick(3);
    rdc(8'h13, 8'h02);
    rdc(8'h14, 8'h80);
    patternTestPassed = 1'h0;
    tick(3);
    rdc(8'h14, 8'h00);
    host.xfer(1'h1, 8'h0E, 8'h00, q, v);
    tick(2);
    chk({6'h0, pin1DriveLevel, pin0DriveLevel}, 8'h00);
    // A reset in mid-run must bring every output except regRdData back to its reset level.
    reset_n = 1'h0;
    tick(2);
    chk({1'h0, errorOut, inputForwardLevel, regRdValid, bridgeSlaveTimeoutSel, pin1DriveLevel, pin0DriveLevel}, 8'h0B);
    reset_n = 1'h1;
    tick(2);
    rdc(8'h0E, 8'h7B);
    chkb(inputForwardLevel, 1'h1);
    report_and_stop;
  end
endmodule // test_deser_status_gpio_regs
`default_nettype wire
